// ---- hdl/adcids_pkg.sv ----
// adcids_pkg: constants and types of the identity and status register pair
package adcids_pkg;

  // ***********************************************************************
  // register map
  // ***********************************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 8;
  localparam logic [ADDR_W-1:0] IDENT_ADDR = 6'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h01;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 16'h0000;

  // ***********************************************************************
  // identity fields
  // ***********************************************************************
  localparam int IDENT_TOP_LSB = 12;
  localparam int IDENT_CNT_LSB = 8;
  localparam int IDENT_REV_LSB = 0;
  localparam logic [3:0] CHANNEL_QUANTITY = 4'h8;
  // arbitrary values: identity nibble and revision byte
  localparam logic [3:0] IDENT_TOP_DEF = 4'h5;
  localparam logic [7:0] IDENT_REV_DEF = 8'hA5;

  // ***********************************************************************
  // status fields and reset values
  // ***********************************************************************
  localparam int ST_LOCK_BIT = 15;
  localparam int ST_RESYNC_BIT = 14;
  localparam int ST_REGMAP_BIT = 13;
  localparam int ST_CRCERR_BIT = 12;
  localparam int ST_CRCTYPE_BIT = 11;
  localparam int ST_RESET_BIT = 10;
  localparam int ST_WSIZE_LSB = 8;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0500;
  localparam logic [1:0] WSIZE_16 = 2'h0;
  localparam logic [1:0] WSIZE_24 = 2'h1;
  localparam logic [1:0] WSIZE_32_ZERO = 2'h2;
  localparam logic [1:0] WSIZE_32_SIGN = 2'h3;
  localparam logic CRC_CCITT = 1'b0;
  localparam logic CRC_ANSI = 1'b1;

  // status word, msb first, laid out as it reads
  typedef struct packed {
    logic lock;
    logic conversion_resync_flag;
    logic regmap_crc_changed;
    logic rx_crc_error;
    logic crc_type;
    logic reset_seen;
    logic [1:0] word_size_select;
    logic [NUM_CH-1:0] new_sample_flag;
  } adcids_status_s;

  // event inputs from the converter and the serial interface
  typedef struct packed {
    logic resync;
    logic regmap_crc_change;
    logic rx_crc_error;
    logic reset_flag_clear;
    logic [NUM_CH-1:0] conv_done;
    logic [NUM_CH-1:0] shifted_out;
  } adcids_event_s;

endpackage : adcids_pkg

// ---- hdl/adcids_regs.sv ----
// adcids_regs: read-only identity and status registers with flag upkeep
//
// Behaviour
// RULE1 - identity register at address 00h is read-only; writes ignored.
// RULE2 - identity low byte is a revision value; host must not rely on it.
// RULE3 - status register at address 01h is read-only and resets to 0500h.
// RULE4 - status bit 15 shows interface lock; unlocked after reset.
// RULE5 - status bit 14 sets on every conversion resync; zero otherwise. Here it stays set until the next status read.
// RULE6 - status bit 13 sets when the register-map checksum changes.
// RULE7 - status bit 12 sets once an input checksum error is seen.
// RULE8 - status bit 11 shows checksum type: 0 CCITT default, 1 ANSI.
// RULE9 - status bit 10 reads 1 after reset and 0 once cleared.
// RULE10 - status bits 9:8 show word size; 24 bits after reset.
// RULE11 - status bits 7:0 show per-channel new data; zero after reset.
// RULE12 - host clears the reset flag by writing 0 to the mode reset bit.
// RULE13 - channel new-data flag clears when shifted out, sets on next result.
`timescale 1ns/1ps
module adcids_regs
  import adcids_pkg::*;
#(
  parameter logic [3:0] IDENT_TOP = IDENT_TOP_DEF,
  parameter logic [7:0] IDENT_REV = IDENT_REV_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic lock_i,
  input wire logic crc_type_i,
  input wire logic [1:0] word_size_select_i,
  input wire adcids_event_s event_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rd_valid_o,
  output adcids_status_s status_o
);

  // ***********************************************************************
  // status state
  // ***********************************************************************
  adcids_status_s status_q;
  adcids_status_s status_d;
  logic status_read;
  logic [DATA_W-1:0] ident_word;

  assign status_read = rd_en_i && (addr_i == STATUS_ADDR);
  assign ident_word = {IDENT_TOP, CHANNEL_QUANTITY, IDENT_REV}; // [RULE2]

  // sticky flags clear on a status read; a same-cycle event wins the clear
  always_comb begin
    status_d = status_q;
    status_d.lock = lock_i; // [RULE4]
    status_d.crc_type = crc_type_i; // [RULE8]
    status_d.word_size_select = word_size_select_i; // [RULE10]
    status_d.conversion_resync_flag = event_i.resync ||
      (status_q.conversion_resync_flag && !status_read); // [RULE5]
    status_d.regmap_crc_changed = event_i.regmap_crc_change ||
      (status_q.regmap_crc_changed && !status_read); // [RULE6]
    status_d.rx_crc_error = event_i.rx_crc_error ||
      (status_q.rx_crc_error && !status_read); // [RULE7]
    status_d.reset_seen = status_q.reset_seen &&
      !event_i.reset_flag_clear; // [RULE9] [RULE12]
  end

  // ***********************************************************************
  // per-channel new-data flags
  // ***********************************************************************
  logic [NUM_CH-1:0] new_flag_d;

  // a completing conversion beats the shift-out of the older result
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_new_flag
    always_comb begin
      new_flag_d[ch] = event_i.conv_done[ch] ||
        (status_q.new_sample_flag[ch] && !event_i.shifted_out[ch]); // [RULE13]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      status_q <= adcids_status_s'(STATUS_RESET); // [RULE3] [RULE11]
    end else begin
      status_q <= {status_d[DATA_W-1:NUM_CH], new_flag_d};
    end
  end

  // ***********************************************************************
  // read port
  // ***********************************************************************
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic rd_valid_q;
  logic rd_valid_d;

  // writes are accepted and dropped: both words are read-only
  always_comb begin
    rd_valid_d = rd_en_i;
    rdata_d = rdata_q;
    if (rd_en_i) begin
      if (addr_i == IDENT_ADDR) begin
        rdata_d = ident_word; // [RULE1]
      end else if (addr_i == STATUS_ADDR) begin
        rdata_d = status_q; // [RULE3]
      end else begin
        rdata_d = UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= UNMAPPED_DATA;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rd_valid_o = rd_valid_q;
  assign status_o = status_q;

  // ***********************************************************************
  // checks
  // ***********************************************************************
  sequence s_ident_read;
    rd_en_i && addr_i == IDENT_ADDR;
  endsequence

  sequence s_status_read;
    rd_en_i && addr_i == STATUS_ADDR;
  endsequence

  a_ident_read_value: assert property ( // [RULE1]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_ident_read |=> rd_valid_o && rdata_o == ident_word)
    else $error("identity read returned wrong word");

  a_ident_write_ignored: assert property ( // [RULE1]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == IDENT_ADDR ##[1:4] s_ident_read
      |=> rdata_o[15:8] == {IDENT_TOP, CHANNEL_QUANTITY})
    else $error("identity word changed after a write");

  a_status_reset_val: assert property ( // [RULE3]
    @(posedge ref_clk_i)
    !rst_n_i |=> status_o == adcids_status_s'(STATUS_RESET))
    else $error("status not 0500h after reset");

  a_lock_follows: assert property ( // [RULE4]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 status_o.lock == $past(lock_i))
    else $error("lock bit does not follow interface lock");

  a_resync_sticky: assert property ( // [RULE5]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.resync |=> status_o.conversion_resync_flag
      until (rd_valid_o && rdata_o[ST_RESYNC_BIT]))
    else $error("resync flag lost before being read");

  a_resync_bounded: assert property ( // [RULE5]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.resync ##1 s_status_read |=> rdata_o[ST_RESYNC_BIT])
    else $error("resync flag not reported");

  a_regmap_set: assert property ( // [RULE6]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.regmap_crc_change |=> status_o.regmap_crc_changed)
    else $error("checksum change not flagged");

  a_crcerr_set: assert property ( // [RULE7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.rx_crc_error |=> status_o.rx_crc_error)
    else $error("input checksum error not flagged");

  a_crc_type_follow: assert property ( // [RULE8]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(crc_type_i) |=> status_o.crc_type == $past(crc_type_i))
    else $error("checksum type not reported");

  a_reset_flag_hold: assert property ( // [RULE9]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !status_o.reset_seen |=> !status_o.reset_seen)
    else $error("reset flag set again without a reset");

  a_reset_flag_clear: assert property ( // [RULE9]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.reset_flag_clear |=> !status_o.reset_seen)
    else $error("reset flag not cleared");

  a_wsize_report: assert property ( // [RULE10]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 status_o.word_size_select == $past(word_size_select_i))
    else $error("word size not reported");

  a_flag_set_each: assert property ( // [RULE11]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    event_i.conv_done != '0 |=> (status_o.new_sample_flag &
      $past(event_i.conv_done)) == $past(event_i.conv_done))
    else $error("channel flag not set by a new result");

  a_flag_clear_shift: assert property ( // [RULE13]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (event_i.shifted_out & ~event_i.conv_done) != '0
      |=> (status_o.new_sample_flag & $past(event_i.shifted_out) &
           ~$past(event_i.conv_done)) == '0)
    else $error("channel flag did not clear on shift-out");

  a_flag_set_wins: assert property ( // [RULE13]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (event_i.conv_done & event_i.shifted_out) != '0
      |=> (status_o.new_sample_flag &
           $past(event_i.conv_done)) == $past(event_i.conv_done))
    else $error("new result lost against shift-out");

endmodule : adcids_regs

// ---- tb/adcids_host.sv ----
// adcids_host: host controller model issuing register reads and writes
`timescale 1ns/1ps
module adcids_host
  import adcids_pkg::*;
(
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);
  // ***********************************************************************
  // bus cycles, driven at the falling edge
  // ***********************************************************************
  initial begin
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 16'h0000;
  end

  // answer strobe stands one cycle only, so it is sampled in that cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    addr_o = ~a;
    d = (rd_valid_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask

  // all registers here are read-only; a write must leave no trace
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = v;
    wr_en_o = 1'b1;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wdata_o = ~v;
  endtask
endmodule // adcids_host

// ---- tb/adcids_regs_tb.sv ----
// adcids_regs_tb: self-checking bench of the identity and status registers
`timescale 1ns/1ps
module adcids_regs_tb
  import adcids_pkg::*;
  ;
  logic ref_clk_i, rst_n_i, rd_en, wr_en, rd_valid, lock, crc_t;
  logic [1:0] wsz;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  adcids_event_s ev;
  adcids_status_s st;
  int mismatches, n_compared;
  // ***********************************************************************
  // instances and helpers
  // ***********************************************************************
  adcids_regs i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
    .lock_i(lock), .crc_type_i(crc_t), .word_size_select_i(wsz),
    .event_i(ev), .rdata_o(rdata), .rd_valid_o(rd_valid), .status_o(st));
  adcids_host i_host (.clk_i(ref_clk_i), .rd_valid_i(rd_valid),
    .rdata_i(rdata), .rd_en_o(rd_en), .wr_en_o(wr_en), .addr_o(addr),
    .wdata_o(wdata));
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle event pulse; status has registered it by the closing edge
  task automatic pulse(input adcids_event_s e);
    @(negedge ref_clk_i);
    ev = e;
    @(negedge ref_clk_i);
    ev = '0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ***********************************************************************
  // scenarios
  // ***********************************************************************
  task automatic t_reset_and_writes();
    i_host.rd(STATUS_ADDR, d);
    chk("status after reset", STATUS_RESET, d);
    i_host.wr(IDENT_ADDR, 16'h0000);
    i_host.wr(STATUS_ADDR, 16'hFAFF);
    i_host.rd(IDENT_ADDR, d);
    // low byte is a revision value, so only the top byte is judged
    chk("ident top", {8'h00, IDENT_TOP_DEF, CHANNEL_QUANTITY},
        {8'h00, d[15:8]});
    i_host.rd(STATUS_ADDR, d);
    chk("status after write", STATUS_RESET, d);
    i_host.rd(6'h3F, d);
    chk("unmapped", UNMAPPED_DATA, d);
  endtask
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      lock = i[0];
      crc_t = i[1];
      wsz = i[1:0];
      @(negedge ref_clk_i);
      chk("levels", {lock, 3'h0, crc_t, 1'b1, wsz, 8'h00},
          st);
    end
    lock = 1'b0;
    crc_t = CRC_CCITT;
    wsz = WSIZE_24;
  endtask
  task automatic t_sticky();
    adcids_event_s e;
    e = '0;
    e.resync = 1'b1;
    pulse(e);
    chk("resync", 16'h4000, st & 16'h7000);
    e = '0;
    e.regmap_crc_change = 1'b1;
    e.rx_crc_error = 1'b1;
    pulse(e);
    chk("sticky set", 16'h7000, st & 16'h7000);
    i_host.rd(STATUS_ADDR, d);
    chk("sticky read", 16'h7000, d & 16'h7000);
    chk("sticky clear", 16'h0000, st & 16'h7000);
    // read lands one cycle after the resync, before anything clears it
    e = '0;
    e.resync = 1'b1;
    fork
      pulse(e);
      begin
        @(negedge ref_clk_i);
        i_host.rd(STATUS_ADDR, d);
      end
    join
    chk("resync read", 16'h4000, d & 16'h4000);
    chk("resync cleared", 16'h0000, st & 16'h4000);
    e = '0;
    e.reset_flag_clear = 1'b1;
    pulse(e);
    chk("reset flag", 16'h0000, st & 16'h0400);
  endtask
  task automatic t_new_data();
    adcids_event_s e;
    for (int c = 0; c < NUM_CH; c++) begin
      e = '0;
      e.conv_done[c] = 1'b1;
      pulse(e);
      chk("flag set", 16'h0001 << c, st & 16'h00FF);
      // a new result and the shift-out in one cycle: the new result wins
      e.shifted_out[c] = 1'b1;
      pulse(e);
      chk("flag set wins", 16'h0001 << c, st & 16'h00FF);
      e = '0;
      e.shifted_out[c] = 1'b1;
      pulse(e);
      chk("flag clear", 16'h0000, st & 16'h00FF);
    end
  endtask
  // a reset in mid-run must raise the reset flag again
  task automatic t_reset_again();
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk("status after second reset", STATUS_RESET, st);
    i_host.rd(STATUS_ADDR, d);
    chk("read after second reset", STATUS_RESET, d);
  endtask
  // ***********************************************************************
  // clock, reset, sequence, watchdog
  // ***********************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    mismatches = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    lock = 1'b0;
    crc_t = CRC_CCITT;
    wsz = WSIZE_24;
    ev = '0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset_and_writes();
    t_levels();
    t_sticky();
    t_new_data();
    t_reset_again();
    give_verdict();
  end
endmodule // adcids_regs_tb
